// *** design/scr_spi_target.sv ***
`timescale 1ns/1ps
`include "scr_cfg.svh"

module scr_spi_target
    import scr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sclk,
    input wire logic selN,
    input wire logic mosi,
    output logic miso,
    output logic misoOe,
    input wire logic [3:0] checkSeedNibble,
    input wire logic [15:0] sensorWord,
    output logic [2:0] sourceCode,
    input wire logic initDoneLock,
    input wire logic selfTestActive,
    input wire logic internalError,
    input wire logic [1:0] detailedStatus,
    output logic sensorReqPulse,
    output logic frameErrPulse
);

    ////////////////////////////////////////////////////////////////////////
    // Pin edges; inputs are already synchronous to clk_sys

    logic sclk_q;
    logic selN_q;
    logic selFall;
    logic selRise;
    logic sclkRise;
    logic sclkFall;

    // Previous pin levels for edge detection
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sclk_q <= 1'b0;
            selN_q <= 1'b1;
        end
        else
        begin
            sclk_q <= sclk;
            selN_q <= selN;
        end
    end

    // Clock edges only count while selected
    assign selFall = selN_q & ~selN;
    assign selRise = ~selN_q & selN;
    assign sclkRise = ~selN & sclk & ~sclk_q;
    assign sclkFall = ~selN & ~sclk & sclk_q;

    ////////////////////////////////////////////////////////////////////////
    // Bit counter and receive shifter

    logic [5:0] bitCnt_q;
    logic [31:0] rxShift_q;

    // Counts rising edges in the frame; saturates so long frames stay bad
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            bitCnt_q <= 6'h00;
        else if (selFall)
            bitCnt_q <= 6'h00;
        else if (sclkRise && bitCnt_q != 6'h3F)
            bitCnt_q <= bitCnt_q + 6'h01;
    end

    // Command bits arrive most significant first
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rxShift_q <= 32'h0000_0000;
        else if (sclkRise)
            rxShift_q <= {rxShift_q[30:0], mosi};
    end

    ////////////////////////////////////////////////////////////////////////
    // Command and response check registers

    logic [7:0] rxCrc;
    logic [7:0] txCrc;
    logic rxFeed;
    logic txFeed;
    logic txFlush_q;
    logic [31:0] txShift_q;

    assign rxFeed = sclkRise && bitCnt_q < `SCR_FRAME_BITS;
    assign txFeed = sclkRise && bitCnt_q < `SCR_MSG_BITS;

    // Flush one cycle after the last message bit is fed
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            txFlush_q <= 1'b0;
        else
            txFlush_q <= txFeed && bitCnt_q == `SCR_MSG_BITS - 6'h01;
    end

    // Checker sees all 32 received bits, check byte included
    scr_crc8 u_rx_crc (
        .clk_sys(clk_sys),
        .srst(srst),
        .seedLoad(selFall),
        .seedNibble(checkSeedNibble),
        .shiftEn(rxFeed),
        .dataIn(mosi),
        .flushZeros(1'b0),
        .crcOut(rxCrc)
    );

    // Generator sees the bits as they stand on the output line
    scr_crc8 u_tx_crc (
        .clk_sys(clk_sys),
        .srst(srst),
        .seedLoad(selFall),
        .seedNibble(checkSeedNibble),
        .shiftEn(txFeed),
        .dataIn(txShift_q[31]),
        .flushZeros(txFlush_q),
        .crcOut(txCrc)
    );

    ////////////////////////////////////////////////////////////////////////
    // Frame end: judge the command and latch the status

    logic frameGood;
    logic [3:0] rxNib;
    logic isReserved;
    logic [15:0] resvMask;
    scr_rsp_t rspKind_q;
    logic [3:0] nib_q;
    logic [1:0] basic_q;
    logic [1:0] detail_q;
    logic [1:0] basicNow;

    // Good only with 32 bits, zero remainder and the clock parked low
    assign frameGood = bitCnt_q == `SCR_FRAME_BITS && rxCrc == 8'h00
                       && !sclk;
    assign rxNib = rxShift_q[`SCR_NIB_MSB:`SCR_NIB_LSB];
    // One mask bit per nibble; a bit select keeps the width exact
    assign resvMask = `SCR_RESERVED_MASK;
    assign isReserved = resvMask[rxNib];

    // Error outranks self-test, which outranks init
    always_comb
    begin
        if (internalError)
            basicNow = `SCR_ST_ERROR;
        else if (selfTestActive)
            basicNow = `SCR_ST_SELFTEST;
        else if (!initDoneLock)
            basicNow = `SCR_ST_INIT;
        else
            basicNow = `SCR_ST_NORMAL;
    end

    // Status is frozen at the select rise of the command frame
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            basic_q <= `SCR_ST_INIT;
            detail_q <= 2'h0;
        end
        else if (selRise)
        begin
            basic_q <= basicNow;
            detail_q <= detailedStatus;
        end
    end

    // Decide the kind of the next response; a bad check discards the command
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rspKind_q <= RSP_ERROR;
            nib_q <= 4'h0;
        end
        else if (selRise)
        begin
            nib_q <= rxNib;
            if (!frameGood)
                rspKind_q <= RSP_ERROR;
            else if (rxShift_q[`SCR_CMD_C0])
                rspKind_q <= RSP_SENSOR;
            else
                rspKind_q <= RSP_RESERVED;
        end
    end

    // Requested quantity goes out to the sensor path
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            sourceCode <= 3'h0;
        else if (selRise && frameGood && rxShift_q[`SCR_CMD_C0])
            sourceCode <= rxShift_q[31:29];
    end

    // One-cycle outcome strobes, issued the cycle after the select rise
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sensorReqPulse <= 1'b0;
            frameErrPulse <= 1'b0;
        end
        else
        begin
            sensorReqPulse <= selRise && frameGood
                              && rxShift_q[`SCR_CMD_C0];
            frameErrPulse <= selRise && !frameGood;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response word and output shifter

    logic [31:0] rspWord;

    // Reserved replies zero the sensor word but keep the echo and status bits; only the check byte matters
    always_comb
    begin
        unique case (rspKind_q)
            RSP_SENSOR:
                rspWord = {nib_q, basic_q, sensorWord, detail_q,
                           8'h00};
            RSP_RESERVED:
                rspWord = {nib_q, basic_q, 16'h0000, detail_q, 8'h00};
            default:
                rspWord = {nib_q, `SCR_ST_ERROR, 16'h0000,
                           `SCR_SF_SPI_ERROR, 8'h00};
        endcase
    end

    // Sensor word is sampled at the select fall; check byte enters at bits 31:24 after the 24th bit
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            txShift_q <= 32'h0000_0000;
        else if (selFall)
            txShift_q <= rspWord;
        else if (sclkFall && bitCnt_q == `SCR_MSG_BITS)
            txShift_q <= {txCrc, 24'h00_0000};
        else if (sclkFall)
            txShift_q <= {txShift_q[30:0], 1'b0};
    end

    assign miso = txShift_q[31];
    assign misoOe = ~selN;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cbSys @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    logic [7:0] seedNow;
    assign seedNow = (checkSeedNibble == 4'h0) ? `SCR_SEED_FULL
                                               : {`SCR_SEED_HIGH,
                                                  checkSeedNibble};

    sequence sGoodEnd;
        selRise && frameGood;
    endsequence

    sequence sSensorStart;
        selFall && rspKind_q == RSP_SENSOR;
    endsequence

    AST_SEED_LOAD: assert property (selFall |=> rxCrc == $past(seedNow))
        else $error("check seed not loaded at frame start");

    AST_SAME_SEED: assert property (selFall |=> txCrc == rxCrc)
        else $error("response and command seeds differ");

    AST_BAD_CHECK: assert property (
        selRise && rxCrc != 8'h00 |=> rspKind_q == RSP_ERROR
            && frameErrPulse)
        else $error("bad check did not give error response");

    AST_GOOD_CHECK: assert property (
        sGoodEnd |=> rspKind_q != RSP_ERROR && !frameErrPulse)
        else $error("good command treated as error");

    AST_RESERVED: assert property (
        sGoodEnd ##0 isReserved |=> rspKind_q == RSP_RESERVED)
        else $error("reserved nibble not answered as reserved");

    AST_ECHO: assert property (
        sSensorStart |=> txShift_q[31:28] == $past(nib_q)
            && txShift_q[28] && miso == txShift_q[31])
        else $error("command nibble not echoed");

    AST_SENSOR_WORD: assert property (
        sSensorStart |=> txShift_q[25:10] == $past(sensorWord))
        else $error("sensor word not taken at select fall");

    AST_ERR_STATUS: assert property (
        selRise && internalError |=> basic_q == `SCR_ST_ERROR)
        else $error("internal error not reported first");

    AST_CHECK_BYTE: assert property (
        sclkFall && bitCnt_q == `SCR_MSG_BITS
            |=> txShift_q[31:24] == $past(txCrc))
        else $error("check byte not placed after message");

    AST_FLUSH: assert property (
        txFeed && bitCnt_q == 6'h17 |=> txFlush_q ##1 !txFlush_q)
        else $error("zero flush not issued once");

endmodule

// *** design/scr_cfg.svh ***
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

`define SCR_FRAME_BITS 6'h20
`define SCR_MSG_BITS 6'h18
`define SCR_POLY 8'h2F
`define SCR_SEED_FULL 8'hFF
`define SCR_SEED_HIGH 4'hF
`define SCR_RESERVED_MASK 16'h4455
`define SCR_NIB_MSB 31
`define SCR_NIB_LSB 28
`define SCR_CMD_C0 28
`define SCR_ST_NORMAL 2'h1
`define SCR_ST_INIT 2'h0
`define SCR_ST_SELFTEST 2'h2
`define SCR_ST_ERROR 2'h3
`define SCR_SF_SPI_ERROR 2'h3

`endif

// *** design/scr_pkg.sv ***
package scr_pkg;

    // What the next outgoing frame will carry
    typedef enum logic [1:0] {
        RSP_ERROR,
        RSP_SENSOR,
        RSP_RESERVED
    } scr_rsp_t;

endpackage

// *** design/scr_crc8.sv ***
`timescale 1ns/1ps
`include "scr_cfg.svh"

module scr_crc8
    import scr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic seedLoad,
    input wire logic [3:0] seedNibble,
    input wire logic shiftEn,
    input wire logic dataIn,
    input wire logic flushZeros,
    output logic [7:0] crcOut
);

    logic [7:0] crc_q;
    logic [7:0] seedVal;
    logic [7:0] flushVal;

    // One serial step: shift the bit into the LSB, fold the polynomial
    function automatic logic [7:0] crcStep(input logic [7:0] c,
                                           input logic b);
        crcStep = {c[6:0], b} ^ (c[7] ? `SCR_POLY : 8'h00);
    endfunction

    // Zero seed nibble selects the all-ones seed
    always_comb
    begin
        seedVal = (seedNibble == 4'h0) ? `SCR_SEED_FULL
                                       : {`SCR_SEED_HIGH, seedNibble};
    end

    // Eight zero steps in one cycle, so the byte is ready before it is sent
    always_comb
    begin
        flushVal = crc_q;
        for (int i = 0; i < 8; i++)
        begin
            flushVal = crcStep(flushVal, 1'b0);
        end
    end

    // Register reseeds per frame and advances one step per serial bit
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            crc_q <= `SCR_SEED_FULL;
        else if (seedLoad)
            crc_q <= seedVal;
        else if (flushZeros)
            crc_q <= flushVal;
        else if (shiftEn)
            crc_q <= crcStep(crc_q, dataIn);
    end

    assign crcOut = crc_q;

endmodule

// *** tb/scr_host_model.sv ***
`timescale 1ns/1ps

module scr_host_model
(
    input wire logic clk_sys,
    output logic sclk,
    output logic selN,
    output logic mosi,
    input wire logic miso
);
    // Idle link: select high, clock low
    initial
    begin
        sclk = 1'b0;
        selN = 1'b1;
        mosi = 1'b0;
    end

    // Whole cycles, then step just off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Message then eight zeros; the result is the check byte
    function automatic logic [7:0] crc8(input logic [23:0] m,
        input logic [3:0] s);
        logic [7:0] c;
        c = (s == 4'h0) ? 8'hFF : {4'hF, s};
        for (int i = 31; i >= 0; i--)
            c = {c[6:0], i > 7 ? m[i - 8] : 1'b0} ^ (c[7] ? 8'h2F : 8'h00);
        return c;
    endfunction

    // Request word with its check byte in the lowest byte
    function automatic logic [31:0] req(input logic [3:0] nib,
        input logic [19:0] mid, input logic [3:0] s);
        return {nib, mid, crc8({nib, mid}, s)};
    endfunction

    // Mode 0 frame; a short count is only sent when asked for
    task automatic xfer(input logic [31:0] cmd, input int nb, input int hp,
        output logic [31:0] rsp);
        rsp = 32'h0;
        selN = 1'b0;
        for (int i = 31; i > 31 - nb; i--)
        begin
            mosi = cmd[i];
            tick(hp);
            sclk = 1'b1;
            rsp = {rsp[30:0], miso};
            tick(hp);
            sclk = 1'b0;
        end
        tick(hp);
        selN = 1'b1;
        mosi = ~mosi; // Released line must not look like held data
        tick(hp);
    endtask
endmodule

// *** tb/test_scr_spi_target.sv ***
`timescale 1ns/1ps

module test_scr_spi_target;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic sclk, selN, mosi, miso, misoOe, reqP, errP;
    logic [3:0] seed = 4'h0;
    logic [3:0] nib, expNib;
    logic [15:0] word = 16'h0;
    logic [2:0] sourceCode;
    logic initDone = 1'b1;
    logic selfTest = 1'b0;
    logic intErr = 1'b0;
    logic [1:0] detSt = 2'h0;
    logic [31:0] rnd = 32'hA54357F0;
    logic [31:0] rsp, cmd;
    logic [19:0] curBody, expBody;
    logic [3:0] resv [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'hA, 4'hE};
    int n_fail = 0;
    int comparisons = 0;
    int nReq = 0;
    int nErr = 0;
    int cyc = 0;
    int n0, e0;

    always #50 clk_sys = ~clk_sys;

    scr_spi_target i_scr_spi_target (.clk_sys(clk_sys), .srst(srst),
        .sclk(sclk), .selN(selN), .mosi(mosi), .miso(miso),
        .misoOe(misoOe), .checkSeedNibble(seed), .sensorWord(word),
        .sourceCode(sourceCode), .initDoneLock(initDone),
        .selfTestActive(selfTest), .internalError(intErr),
        .detailedStatus(detSt), .sensorReqPulse(reqP),
        .frameErrPulse(errP));

    scr_host_model i_scr_host_model (.clk_sys(clk_sys), .sclk(sclk),
        .selN(selN), .mosi(mosi), .miso(miso));

    ////////////////////////////////////////////////////////////////////////
    // Pulse counters and the hang guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (reqP === 1'b1) nReq++;
        if (errP === 1'b1) nErr++;
        if (cyc == 40000)
        begin
            n_fail++;
            final_report;
        end
    end

    function automatic logic [31:0] nextRnd(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Error wins, then self-test, then unfinished init
    function automatic logic [1:0] basic(input logic e, t, d);
        if (e) return 2'h3;
        if (t) return 2'h2;
        return d ? 2'h1 : 2'h0;
    endfunction

    task automatic check(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One frame at a random speed; inputs move mid-frame so that a late
    // or early sample of word or status shows in the next reply
    task automatic frame(input logic [31:0] c, input int nb);
        logic [7:0] sum;
        rnd = nextRnd(rnd);
        fork
            i_scr_host_model.xfer(c, nb, 3 + rnd[1:0], rsp);
            begin
                i_scr_host_model.tick(20);
                check(misoOe, 1, "enable");
                intErr = (rnd[10:8] == 3'h0);
                selfTest = (rnd[13:11] == 3'h0);
                initDone = rnd[14] | rnd[15];
                detSt = rnd[17:16];
                word = rnd[31:16] ^ rnd[15:0];
            end
        join
        curBody = {basic(intErr, selfTest, initDone), word, detSt};
        // A cut frame loses the tail of its reply, so only full ones sum
        sum = i_scr_host_model.crc8(rsp[31:8], seed);
        if (nb == 32)
            check(rsp[7:0], sum, "crc");
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_scr_host_model.tick(2);
        srst = 1'b0;
        i_scr_host_model.tick(1);
        // First reply after reset is the error reply
        frame(i_scr_host_model.req(4'h1, 20'h0, seed), 32);
        check(rsp[27:8], {2'h3, 16'h0, 2'h3}, "reset reply");
        expNib = 4'h1;
        expBody = curBody;
        $display("test reset done");
        for (int k = 0; k < 24; k++)
        begin
            seed = rnd[3] ? rnd[7:4] : 4'h0;
            nib = {rnd[6:4], 1'b1};
            n0 = nReq;
            frame(i_scr_host_model.req(nib, 20'h0, seed), 32);
            check(rsp[31:8], {expNib, expBody}, "sensor reply");
            check(nReq - n0, 1, "request pulse");
            check(sourceCode, nib[3:1], "source");
            expNib = nib;
            expBody = curBody;
        end
        $display("test sensor done");
        // Reserved codes: no action, reply checked for its check byte
        foreach (resv[i])
        begin
            n0 = nReq + nErr;
            frame(i_scr_host_model.req(resv[i], rnd[27:8], seed), 32);
            check(nReq + nErr - n0, 0, "reserved pulse");
        end
        frame(i_scr_host_model.req(4'h3, 20'h0, seed), 32);
        expBody = curBody;
        $display("test reserved done");
        // Bad count, then bad check byte: dropped, error reply follows
        for (int j = 0; j < 2; j++)
        begin
            e0 = nErr;
            cmd = i_scr_host_model.req(4'hF, 20'h0, seed);
            frame(cmd ^ j, 32 - (1 - j));
            // The refused frame still carried the reply to the last request
            cmd = rsp << (1 - j);
            check(cmd[31:8], {4'h3, expBody}, "refused reply");
            check(nErr - e0, 1, "error pulse");
            check(sourceCode, 3'h1, "dropped");
            frame(i_scr_host_model.req(4'h3, 20'h0, seed), 32);
            check(rsp[27:8], {2'h3, 16'h0, 2'h3}, "error reply");
            expBody = curBody;
        end
        $display("test refusal done");
        final_report;
    end
endmodule
